/* File: hdl/mrf_mode_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrf_defs.svh"

module mrf_mode_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire mrf_pkg::mrf_cmd_type cmd,
	input wire logic [1:0] zq_pin_state,
	input wire logic [2:0] refresh_rate_pin,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dqs_oe,
	output mrf_pkg::mrf_feature_type feature,
	output logic [3:0] precharge_delay,
	output logic [3:0] latency_code,
	output logic [3:0] drive_strength,
	output logic [7:0] test_mode,
	output logic [7:0] bank_mask,
	output logic [7:0] segment_mask,
	output logic [3:0] burst_start_col,
	output logic zq_cal_start,
	output logic factory_trim,
	output logic device_reset_pulse,
	output logic auto_init_status
);

	// Registers that accept no write.
	function automatic logic is_read_only(input logic [7:0] a);
		case (a)
			`MRF_ADDR_INFO, `MRF_ADDR_REFRESH, `MRF_ADDR_MAKER, `MRF_ADDR_REV1,
			`MRF_ADDR_REV2, `MRF_ADDR_GEOM, `MRF_ADDR_PAT_A, `MRF_ADDR_PAT_B:
				is_read_only = 1'b1;
			default: is_read_only = 1'b0;
		endcase
	endfunction : is_read_only

	// Bits that may be stored for each writable register.
	function automatic logic [7:0] keep_mask(input logic [7:0] a);
		case (a)
			`MRF_ADDR_FEAT2, `MRF_ADDR_IOCFG: keep_mask = `MRF_MASK_NIBBLE;
			default: keep_mask = `MRF_MASK_FULL;
		endcase
	endfunction : keep_mask

	logic mrw;
	logic mrr_take;
	logic [7:0] wr_data;
	logic init_rst;
	logic [1:0] zq_meta;
	logic [1:0] zq_sync;
	logic [2:0] rate_meta;
	logic [2:0] rate_sync;
	logic [2:0] rate_prev;
	logic temp_update_flag;
	logic [1:0] resistor_selftest_result;
	logic [`MRF_AI_CNT_W-1:0] ai_cnt;
	logic [`MRF_ZQ_CNT_W-1:0] zq_cnt;
	logic zq_busy;
	logic zq_is_init;
	logic [7:0] rom_data;
	logic [7:0] rd_addr;
	logic [1:0] beat;
	logic [7:0] info_value;
	logic [7:0] rd_value;
	logic tuf_clear;
	mrf_pkg::mrf_rd_state_type rd_state;

	assign mrw = (cmd.kind == mrf_pkg::MRF_CMD_MRW);
	assign mrr_take = (cmd.kind == mrf_pkg::MRF_CMD_MRR) && (rd_state == mrf_pkg::MRF_RD_IDLE);
	assign wr_data = cmd.op_code_bits & keep_mask(cmd.register_address);
	assign init_rst = rst | device_reset_pulse;

	// The pins are asynchronous to the device clock.
	always_ff @(posedge clk_sys) begin
		zq_meta <= zq_pin_state;
		zq_sync <= zq_meta;
		rate_meta <= refresh_rate_pin;
		rate_sync <= rate_meta;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			device_reset_pulse <= 1'b0;
		end else begin
			device_reset_pulse <= mrw && (cmd.register_address == `MRF_ADDR_RESET);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			auto_init_status <= 1'b1;
			ai_cnt <= `MRF_AI_CNT_W'(`MRF_AI_CYCLES - 1);
		end else if (auto_init_status) begin
			if (ai_cnt == '0) begin
				auto_init_status <= 1'b0;
			end else begin
				ai_cnt <= ai_cnt - 1'b1;
			end
		end
	end

	// Feature register; reserved length and recovery codes leave the field unchanged.
	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			feature <= mrf_pkg::mrf_feature_type'(`MRF_F1_RESET);
		end else if (mrw && cmd.register_address == `MRF_ADDR_FEAT1) begin
			feature.wrap_control <= wr_data[`MRF_F1_WRAP];
			feature.burst_type <= wr_data[`MRF_F1_TYPE];
			if (wr_data[`MRF_F1_LEN] == `MRF_LEN_4 || wr_data[`MRF_F1_LEN] == `MRF_LEN_8 ||
					wr_data[`MRF_F1_LEN] == `MRF_LEN_16) begin
				feature.burst_length <= wr_data[`MRF_F1_LEN];
			end
			if (wr_data[`MRF_F1_REC] >= `MRF_REC_MIN && wr_data[`MRF_F1_REC] <= `MRF_REC_MAX) begin
				feature.write_recovery_count <= wr_data[`MRF_F1_REC];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			precharge_delay <= `MRF_REC_BIAS + 4'(`MRF_REC_MIN);
		end else begin
			precharge_delay <= `MRF_REC_BIAS + {1'b0, feature.write_recovery_count};
		end
	end

	// Remaining write-only registers; read-only and reserved addresses fall through.
	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			latency_code <= 4'(`MRF_WO_RESET);
			drive_strength <= 4'(`MRF_WO_RESET);
			test_mode <= `MRF_WO_RESET;
			bank_mask <= `MRF_WO_RESET;
			segment_mask <= `MRF_WO_RESET;
		end else if (mrw && !is_read_only(cmd.register_address)) begin
			case (cmd.register_address)
				`MRF_ADDR_FEAT2: latency_code <= wr_data[`MRF_LOW_NIBBLE];
				`MRF_ADDR_IOCFG: drive_strength <= wr_data[`MRF_LOW_NIBBLE];
				`MRF_ADDR_TEST: test_mode <= wr_data;
				`MRF_ADDR_BANK: bank_mask <= wr_data;
				`MRF_ADDR_SEG: segment_mask <= wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			burst_start_col <= '0;
		end else if (cmd.kind == mrf_pkg::MRF_CMD_BURST) begin
			burst_start_col <= {cmd.col_hi, 1'b0};
		end
	end

	// Impedance calibration and the resistor self-test.
	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			zq_busy <= 1'b0;
			zq_is_init <= 1'b0;
			zq_cnt <= '0;
			zq_cal_start <= 1'b0;
			resistor_selftest_result <= `MRF_RZQ_UNSUP;
		end else begin
			zq_cal_start <= 1'b0;
			if (mrw && cmd.register_address == `MRF_ADDR_ZQCAL && !factory_trim && !zq_busy) begin
				zq_cal_start <= 1'b1;
				zq_busy <= 1'b1;
				zq_is_init <= (cmd.op_code_bits == `MRF_ZQ_INIT_CODE);
				zq_cnt <= `MRF_ZQ_CNT_W'(`MRF_ZQ_CYCLES - 1);
			end else if (zq_busy) begin
				if (zq_cnt == '0) begin
					zq_busy <= 1'b0;
					if (zq_is_init && `MRF_SELFTEST_SUPPORTED) begin
						resistor_selftest_result <= zq_sync;
					end
				end else begin
					zq_cnt <= zq_cnt - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			factory_trim <= 1'b0;
		end else begin
			factory_trim <= (resistor_selftest_result == `MRF_RZQ_VDD) ||
				(resistor_selftest_result == `MRF_RZQ_GND);
		end
	end

	// Refresh-rate change flag; a new change beats the clear by a read.
	assign tuf_clear = (rd_state == mrf_pkg::MRF_RD_WAIT) && (rd_addr == `MRF_ADDR_REFRESH);

	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			rate_prev <= rate_sync;
			temp_update_flag <= 1'b0;
		end else begin
			rate_prev <= rate_sync;
			if (rate_prev != rate_sync) begin
				temp_update_flag <= 1'b1;
			end else if (tuf_clear) begin
				temp_update_flag <= 1'b0;
			end
		end
	end

	mrf_id_rom u_rom (
		.clk_sys(clk_sys),
		.addr(cmd.register_address),
		.data(rom_data)
	);

	always_comb begin
		info_value = '0;
		info_value[`MRF_INFO_INIT] = auto_init_status;
		info_value[`MRF_INFO_TYPE] = `MRF_DEVICE_TYPE;
		info_value[`MRF_INFO_INVALID] = `MRF_INVALID_SUPPORT;
		info_value[`MRF_INFO_SELFTEST] = resistor_selftest_result;
	end

	always_comb begin
		case (rd_addr)
			`MRF_ADDR_INFO: rd_value = info_value;
			`MRF_ADDR_REFRESH: rd_value = {temp_update_flag, 4'h0, rate_sync};
			`MRF_ADDR_MAKER, `MRF_ADDR_REV1, `MRF_ADDR_REV2, `MRF_ADDR_GEOM,
			`MRF_ADDR_PAT_A, `MRF_ADDR_PAT_B: rd_value = rom_data;
			default: rd_value = `MRF_UNDEF_DATA;
		endcase
	end

	// Read burst: one wait cycle, then four strobed beats with the value on the first.
	always_ff @(posedge clk_sys) begin
		if (init_rst) begin
			rd_state <= mrf_pkg::MRF_RD_IDLE;
			rd_addr <= '0;
			beat <= '0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe <= 1'b0;
		end else begin
			case (rd_state)
				mrf_pkg::MRF_RD_IDLE: begin
					if (mrr_take) begin
						rd_addr <= cmd.register_address;
						rd_state <= mrf_pkg::MRF_RD_WAIT;
					end
				end
				mrf_pkg::MRF_RD_WAIT: begin
					dq_out <= rd_value;
					dq_oe <= 1'b1;
					dqs_oe <= 1'b1;
					dqs_out <= 1'b1;
					beat <= '0;
					rd_state <= mrf_pkg::MRF_RD_BURST;
				end
				mrf_pkg::MRF_RD_BURST: begin
					if (beat == `MRF_RD_LAST_BEAT) begin
						dq_oe <= 1'b0;
						dqs_oe <= 1'b0;
						dqs_out <= 1'b0;
						dq_out <= '0;
						rd_state <= mrf_pkg::MRF_RD_IDLE;
					end else begin
						beat <= beat + 1'b1;
						dq_out <= `MRF_UNDEF_DATA;
						dqs_out <= ~dqs_out;
					end
				end
				default: rd_state <= mrf_pkg::MRF_RD_IDLE;
			endcase
		end
	end

	// Checks.
	logic [7:0] ai_age;
	logic first_beat;

	always_ff @(posedge clk_sys) begin
		if (init_rst || !auto_init_status) begin
			ai_age <= '0;
		end else if (ai_age != 8'hff) begin
			ai_age <= ai_age + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			first_beat <= 1'b0;
		end else begin
			first_beat <= (rd_state == mrf_pkg::MRF_RD_WAIT);
		end
	end

	a_mrr_strobe_burst: assert property (@(posedge clk_sys) disable iff (init_rst)
		mrr_take |-> ##2 (dqs_oe && dqs_out) ##1 (dqs_oe && !dqs_out) ##1 dqs_out ##1 !dqs_out)
		else $error("read burst strobe did not toggle four beats");

	a_info_reserved_zero: assert property (@(posedge clk_sys) disable iff (init_rst)
		(first_beat && rd_addr == `MRF_ADDR_INFO) |-> dq_out[7:5] == 3'b000)
		else $error("reserved info bits not zero");

	a_invalid_bit_zero: assert property (@(posedge clk_sys) disable iff (init_rst)
		(first_beat && rd_addr == `MRF_ADDR_INFO) |-> !dq_out[`MRF_INFO_INVALID])
		else $error("invalid-data support bit set");

	a_ro_write_ignored: assert property (@(posedge clk_sys) disable iff (init_rst)
		(mrw && is_read_only(cmd.register_address)) |=>
		$stable(feature) && $stable(latency_code) && $stable(drive_strength) && $stable(bank_mask))
		else $error("write to read-only register changed state");

	a_length_legal_code: assert property (@(posedge clk_sys) disable iff (rst)
		feature.burst_length inside {`MRF_LEN_4, `MRF_LEN_8, `MRF_LEN_16})
		else $error("burst length holds a reserved code");

	a_recovery_delay_map: assert property (@(posedge clk_sys) disable iff (init_rst)
		$stable(feature.write_recovery_count) |=>
		precharge_delay == `MRF_REC_BIAS + {1'b0, $past(feature.write_recovery_count)})
		else $error("precharge delay does not follow recovery code");

	a_reset_trigger: assert property (@(posedge clk_sys) disable iff (rst)
		(mrw && cmd.register_address == `MRF_ADDR_RESET) |=> device_reset_pulse ##1
		(auto_init_status && feature == mrf_pkg::mrf_feature_type'(`MRF_F1_RESET)))
		else $error("reset register write did not re-initialise");

	a_auto_init_bound: assert property (@(posedge clk_sys) disable iff (rst)
		ai_age <= 8'(`MRF_AI_CYCLES))
		else $error("init status stayed busy too long");

	a_trim_blocks_cal: assert property (@(posedge clk_sys) disable iff (init_rst)
		factory_trim |=> !zq_cal_start)
		else $error("calibration started under factory trim");

	a_burst_col_even: assert property (@(posedge clk_sys) disable iff (init_rst)
		(cmd.kind == mrf_pkg::MRF_CMD_BURST) |=> burst_start_col == {$past(cmd.col_hi), 1'b0})
		else $error("burst start column wrong");

	a_feature_write: assert property (@(posedge clk_sys) disable iff (init_rst)
		(mrw && cmd.register_address == `MRF_ADDR_FEAT1) |=>
		feature.wrap_control == $past(cmd.op_code_bits[`MRF_F1_WRAP]))
		else $error("wrap control not stored");

	c_info_read: cover property (@(posedge clk_sys) first_beat && rd_addr == `MRF_ADDR_INFO);
	c_reset_write: cover property (@(posedge clk_sys) device_reset_pulse);
	c_selftest_done: cover property (@(posedge clk_sys)
		zq_busy && zq_is_init ##1 !zq_busy);
	c_len16_program: cover property (@(posedge clk_sys) feature.burst_length == `MRF_LEN_16);

endmodule : mrf_mode_regs

`default_nettype wire

/* File: hdl/mrf_defs.svh */
`ifndef MRF_DEFS_SVH
`define MRF_DEFS_SVH

// Mode register addresses.
`define MRF_ADDR_INFO 8'h00
`define MRF_ADDR_FEAT1 8'h01
`define MRF_ADDR_FEAT2 8'h02
`define MRF_ADDR_IOCFG 8'h03
`define MRF_ADDR_REFRESH 8'h04
`define MRF_ADDR_MAKER 8'h05
`define MRF_ADDR_REV1 8'h06
`define MRF_ADDR_REV2 8'h07
`define MRF_ADDR_GEOM 8'h08
`define MRF_ADDR_TEST 8'h09
`define MRF_ADDR_ZQCAL 8'h0a
`define MRF_ADDR_BANK 8'h10
`define MRF_ADDR_SEG 8'h11
`define MRF_ADDR_PAT_A 8'h20
`define MRF_ADDR_PAT_B 8'h28
`define MRF_ADDR_RESET 8'h3f

// Field positions.
`define MRF_INFO_INIT 0
`define MRF_INFO_TYPE 1
`define MRF_INFO_INVALID 2
`define MRF_INFO_SELFTEST 4:3
`define MRF_F1_REC 7:5
`define MRF_F1_WRAP 4
`define MRF_F1_TYPE 3
`define MRF_F1_LEN 2:0
`define MRF_LOW_NIBBLE 3:0
`define MRF_FLAG_BIT 7
`define MRF_RATE_BITS 2:0

// Encodings and reset values.
`define MRF_LEN_4 3'b010
`define MRF_LEN_8 3'b011
`define MRF_LEN_16 3'b100
`define MRF_REC_MIN 3'b001
`define MRF_REC_MAX 3'b110
`define MRF_REC_BIAS 4'h2
`define MRF_F1_RESET 8'h22
`define MRF_WO_RESET 8'h00
`define MRF_MASK_NIBBLE 8'h0f
`define MRF_MASK_FULL 8'hff
`define MRF_ZQ_INIT_CODE 8'hff
`define MRF_RZQ_UNSUP 2'b00
`define MRF_RZQ_VDD 2'b01
`define MRF_RZQ_GND 2'b10
`define MRF_SELFTEST_SUPPORTED 1'b1
`define MRF_DEVICE_TYPE 1'b0
`define MRF_INVALID_SUPPORT 1'b0
`define MRF_UNDEF_DATA 8'h00

// Timing.
`define MRF_CLK_KHZ 10000
`define MRF_TINIT5_NS 10000
`define MRF_TZQINIT_NS 1000
`define MRF_AI_CYCLES ((`MRF_TINIT5_NS * `MRF_CLK_KHZ) / 1000000)
`define MRF_ZQ_CYCLES ((`MRF_TZQINIT_NS * `MRF_CLK_KHZ + 999999) / 1000000)
`define MRF_AI_CNT_W 7
`define MRF_ZQ_CNT_W 4
`define MRF_RD_LAST_BEAT 2'd3

`endif

/* File: hdl/mrf_pkg.sv */
package mrf_pkg;

	typedef enum logic [1:0] {
		MRF_CMD_NOP,
		MRF_CMD_MRR,
		MRF_CMD_MRW,
		MRF_CMD_BURST
	} mrf_cmd_kind_type;

	typedef struct packed {
		mrf_cmd_kind_type kind;
		logic [2:0] col_hi;
		logic [7:0] register_address;
		logic [7:0] op_code_bits;
	} mrf_cmd_type;

	typedef struct packed {
		logic [2:0] write_recovery_count;
		logic wrap_control;
		logic burst_type;
		logic [2:0] burst_length;
	} mrf_feature_type;

	typedef enum logic [1:0] {
		MRF_RD_IDLE,
		MRF_RD_WAIT,
		MRF_RD_BURST
	} mrf_rd_state_type;

endpackage : mrf_pkg

/* File: hdl/mrf_id_rom.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mrf_defs.svh"

// Read-only identity and training contents; all parameter values are arbitrary.
module mrf_id_rom #(
	parameter logic [7:0] MAKER_CODE = 8'h00,
	parameter logic [7:0] REVISION_ONE = 8'h00,
	parameter logic [7:0] REVISION_TWO = 8'h00,
	parameter logic [7:0] GEOMETRY = 8'h00,
	parameter logic [7:0] PATTERN_A = 8'h55,
	parameter logic [7:0] PATTERN_B = 8'h33
) (
	input wire logic clk_sys,
	input wire logic [7:0] addr,
	output logic [7:0] data
);

	always_ff @(posedge clk_sys) begin
		case (addr)
			`MRF_ADDR_MAKER: data <= MAKER_CODE;
			`MRF_ADDR_REV1: data <= REVISION_ONE;
			`MRF_ADDR_REV2: data <= REVISION_TWO;
			`MRF_ADDR_GEOM: data <= GEOMETRY;
			`MRF_ADDR_PAT_A: data <= PATTERN_A;
			`MRF_ADDR_PAT_B: data <= PATTERN_B;
			default: data <= `MRF_UNDEF_DATA;
		endcase
	end

endmodule : mrf_id_rom

`default_nettype wire

/* File: sim/mrf_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Controller side of the command bus: one command per call, none from mrw for an unlisted address; read bursts strobe-checked beat by beat, first beat kept.
module mrf_ctrl_model (
	input wire logic clk_sys,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic dqs_out,
	input wire logic dqs_oe,
	output mrf_pkg::mrf_cmd_type cmd
);
	initial begin
		cmd = '0;
	end

	// The command stands for exactly one edge, then the bus returns to a no-operation.
	task automatic issue(input mrf_pkg::mrf_cmd_kind_type kind, input logic [2:0] col,
		input logic [7:0] addr, input logic [7:0] op);
		@(posedge clk_sys);
		cmd <= '{kind, col, addr, op};
		@(posedge clk_sys);
		cmd <= '0;
		#1;
	endtask : issue

	task automatic mrw(input logic [7:0] addr, input logic [7:0] op);
		logic [7:0] clean;
		clean = op;
		if (addr == 8'h02 || addr == 8'h03) begin
			clean = op & 8'h0f;
		end
		if ((addr <= 8'h0a) || addr == 8'h10 || addr == 8'h11 || addr == 8'h20 || addr == 8'h28
			|| addr == 8'h3f) begin
			issue(mrf_pkg::MRF_CMD_MRW, 3'h0, addr, clean);
		end
	endtask : mrw

	// Returns the first beat and whether the strobe ran 1,0,1,0 and then released.
	task automatic mrr(input logic [7:0] addr, output logic [7:0] data, output logic ok);
		issue(mrf_pkg::MRF_CMD_MRR, 3'h0, addr, 8'h00);
		@(posedge clk_sys);
		#1;
		data = dq_out;
		ok = (dq_oe === 1'b1) && (dqs_oe === 1'b1) && (dqs_out === 1'b1);
		for (int i = 1; i < 4; i++) begin
			@(posedge clk_sys);
			#1;
			ok = ok && (dqs_oe === 1'b1) && (dqs_out === ~i[0]);
		end
		@(posedge clk_sys);
		#1;
		ok = ok && (dq_oe === 1'b0) && (dqs_oe === 1'b0);
	endtask : mrr

	task automatic burst(input logic [2:0] col);
		issue(mrf_pkg::MRF_CMD_BURST, col, 8'h00, 8'h00);
	endtask : burst
endmodule : mrf_ctrl_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end

module testbench;
	logic clk_sys;
	logic rst;
	logic [1:0] zq_pin_state;
	logic [2:0] refresh_rate_pin;
	mrf_pkg::mrf_cmd_type cmd;
	logic [7:0] dq_out;
	logic dq_oe;
	logic dqs_out;
	logic dqs_oe;
	mrf_pkg::mrf_feature_type feature;
	logic [3:0] precharge_delay;
	logic [3:0] latency_code;
	logic [3:0] drive_strength;
	logic [7:0] test_mode;
	logic [7:0] bank_mask;
	logic [7:0] segment_mask;
	logic [3:0] burst_start_col;
	logic zq_cal_start;
	logic factory_trim;
	logic device_reset_pulse;
	logic auto_init_status;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] rd;
	logic ok;

	mrf_ctrl_model ctrl (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.dqs_oe(dqs_oe), .cmd(cmd));

	mrf_mode_regs dut (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .zq_pin_state(zq_pin_state),
		.refresh_rate_pin(refresh_rate_pin), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.dqs_oe(dqs_oe), .feature(feature), .precharge_delay(precharge_delay),
		.latency_code(latency_code), .drive_strength(drive_strength), .test_mode(test_mode),
		.bank_mask(bank_mask), .segment_mask(segment_mask), .burst_start_col(burst_start_col),
		.zq_cal_start(zq_cal_start), .factory_trim(factory_trim),
		.device_reset_pulse(device_reset_pulse), .auto_init_status(auto_init_status));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic close_out();
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			$display("[FAIL] %0t run did not complete", $time);
			close_out();
		end
	end

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		ctrl.mrr(addr, rd, ok);
		`CHK(ok, 1'b1)
		`CHK(rd, exp)
	endtask : rd_chk

	task automatic wait_init();
		for (int i = 0; i < 110 && auto_init_status !== 1'b0; i++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK(auto_init_status, 1'b0)
	endtask : wait_init

	task automatic t_reset();
		`CHK(feature, 8'h22)
		`CHK(precharge_delay, 4'd3)
		`CHK(auto_init_status, 1'b1)
		rd_chk(8'h00, 8'h01);
		wait_init();
		rd_chk(8'h00, 8'h00);
	endtask : t_reset

	task automatic t_feature();
		ctrl.mrw(8'h01, 8'h8b);
		`CHK(feature, 8'h8b)
		@(posedge clk_sys);
		#1;
		`CHK(precharge_delay, 4'd6)
		for (int c = 1; c < 7; c++) begin
			ctrl.mrw(8'h01, {c[2:0], 5'b10010});
			@(posedge clk_sys);
			#1;
			`CHK(feature, {c[2:0], 5'b10010})
			`CHK(precharge_delay, c[3:0] + 4'd2)
		end
		ctrl.mrw(8'h01, 8'hfb);
		`CHK(feature, 8'hdb)
		ctrl.mrw(8'h01, 8'h44);
		`CHK(feature, 8'h44)
		ctrl.mrw(8'h01, 8'h23);
		`CHK(feature, 8'h23)
	endtask : t_feature

	task automatic t_store();
		ctrl.mrw(8'h02, 8'hf5);
		`CHK(latency_code, 4'h5)
		ctrl.mrw(8'h03, 8'hff);
		`CHK(drive_strength, 4'hf)
		ctrl.mrw(8'h09, 8'ha5);
		`CHK(test_mode, 8'ha5)
		ctrl.mrw(8'h10, 8'h3c);
		`CHK(bank_mask, 8'h3c)
		ctrl.mrw(8'h11, 8'hc3);
		`CHK(segment_mask, 8'hc3)
	endtask : t_store

	task automatic t_write_only();
		ctrl.mrr(8'h01, rd, ok);
		`CHK(ok, 1'b1)
		ctrl.mrr(8'h0b, rd, ok);
		`CHK(ok, 1'b1)
	endtask : t_write_only

	task automatic t_burst();
		ctrl.burst(3'b101);
		`CHK(burst_start_col, 4'b1010)
		ctrl.burst(3'b011);
		`CHK(burst_start_col, 4'b0110)
	endtask : t_burst

	task automatic t_reset_reg();
		ctrl.mrw(8'h01, 8'h8b);
		ctrl.mrw(8'h3f, 8'ha5);
		for (int i = 0; i < 3 && device_reset_pulse !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK(device_reset_pulse, 1'b1)
		@(posedge clk_sys);
		#1;
		`CHK(feature, 8'h22)
		`CHK(auto_init_status, 1'b1)
		wait_init();
	endtask : t_reset_reg

	task automatic t_zq();
		logic [1:0] codes [3] = '{2'b11, 2'b10, 2'b01};
		foreach (codes[k]) begin
			t_reset_reg();
			@(posedge clk_sys);
			zq_pin_state <= codes[k];
			repeat (4) @(posedge clk_sys);
			ctrl.mrw(8'h0a, 8'hff);
			`CHK(zq_cal_start, 1'b1)
			repeat (12) @(posedge clk_sys);
			rd_chk(8'h00, {3'b000, codes[k], 3'b000});
			`CHK(factory_trim, codes[k] != 2'b11)
		end
		ctrl.mrw(8'h0a, 8'hff);
		`CHK(zq_cal_start, 1'b0)
	endtask : t_zq

	task automatic t_readonly();
		ctrl.mrw(8'h00, 8'hff);
		ctrl.mrw(8'h20, 8'h00);
		ctrl.mrw(8'h28, 8'h00);
		ctrl.mrw(8'h05, 8'hff);
		`CHK(feature, 8'h22)
		`CHK(factory_trim, 1'b1)
		rd_chk(8'h00, 8'h08);
		rd_chk(8'h20, 8'h55);
		rd_chk(8'h28, 8'h33);
		rd_chk(8'h05, 8'h00);
		@(posedge clk_sys);
		refresh_rate_pin <= 3'b011;
		repeat (4) @(posedge clk_sys);
		rd_chk(8'h04, 8'h83);
		rd_chk(8'h04, 8'h03);
	endtask : t_readonly

	initial begin
		rst = 1'b1;
		zq_pin_state = 2'b00;
		refresh_rate_pin = 3'b000;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		t_reset();
		t_feature();
		t_store();
		t_write_only();
		t_burst();
		t_reset_reg();
		t_zq();
		t_readonly();
		close_out();
	end
endmodule : testbench
`default_nettype wire
